// [design/fcsu_top.v]
// Flash command launch and status unit with APB register port
`timescale 1ns/1ps
`include "fcsu_consts.vh"

module fcsu_top #(
	parameter AW = 16
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire stop_req,
	input wire key_ok,
	input wire [1:0] sec_strap,
	output reg [1:0] security_state_code,
	output reg irq,
	input wire arr_done,
	input wire arr_rvalid,
	input wire [7:0] arr_rdata,
	output wire arr_req,
	output wire [2:0] arr_op,
	output wire [AW-1:0] arr_addr,
	output wire [7:0] arr_wdata,
	output wire arr_abort
);

	// ======================================================
	// State
	reg cmd_buffer_empty_flag_reg;
	reg cmd_complete_flag_reg;
	reg protect_violation_flag_reg;
	reg access_error_flag_reg;
	reg array_blank_flag_reg;
	reg [7:0] flash_command_code_reg;
	reg loaded_reg;
	reg [AW-1:0] addr_reg;
	reg [7:0] data_reg;
	reg div_ready_reg;
	reg prot_en_reg;
	reg [AW-1:0] prot_base_reg;
	reg pend_reg;
	reg [2:0] pend_op_reg;
	reg pend_burst_reg;
	reg [AW-1:0] pend_addr_reg;
	reg [7:0] pend_data_reg;
	reg cur_blank_reg;
	reg cur_burst_reg;
	reg [`FCSU_IRQ_W-1:0] istat_reg;
	reg [`FCSU_IRQ_W-1:0] imask_reg;
	reg sec_loaded_reg;
	reg [31:0] rdata_next;
	reg [AW-1:0] target;

	wire d_legal;
	wire d_prog;
	wire d_burst;
	wire d_blank;
	wire d_mass;
	wire d_page;
	wire [2:0] d_op;
	wire arr_busy;
	wire arr_fin;
	wire arr_blank_ok;

	// ======================================================
	// Address decode, shared by write decode and error answer
	function known_addr;
		input [7:0] a;
		begin
			case (a)
				`FCSU_OFF_STATUS, `FCSU_OFF_CMD, `FCSU_OFF_ADDR,
				`FCSU_OFF_DATA, `FCSU_OFF_CTRL, `FCSU_OFF_SEC,
				`FCSU_OFF_ISTAT, `FCSU_OFF_IMASK: known_addr = 1'b1;
				default: known_addr = 1'b0;
			endcase
		end
	endfunction

	// Transfer completes at the edge where our pready is seen high
	wire xfer = psel && penable && pready;
	wire wr = xfer && pwrite && known_addr(paddr);
	wire wr_stat = wr && (paddr == `FCSU_OFF_STATUS);
	wire wr_load = wr && ((paddr == `FCSU_OFF_CMD) ||
		(paddr == `FCSU_OFF_ADDR) || (paddr == `FCSU_OFF_DATA));

	// ======================================================
	// Command decode of the loaded code
	fcsu_cmd_decode u_dec (
		.code(flash_command_code_reg),
		.legal(d_legal),
		.is_prog(d_prog),
		.is_burst(d_burst),
		.is_blank(d_blank),
		.is_mass(d_mass),
		.is_page(d_page),
		.op(d_op)
	);

	// ======================================================
	// Launch checks
	wire busy = arr_busy || pend_reg;
	// Writing zero, or one while the buffer is full, launches nothing
	wire launch_try = wr_stat && pwdata[`FCSU_BIT_CBEF] && cmd_buffer_empty_flag_reg;
	// Only a burst may follow a running burst
	wire seq_err = !loaded_reg || protect_violation_flag_reg || access_error_flag_reg ||
		(busy && !(cur_burst_reg && d_burst));
	wire clk_err = d_prog && !div_ready_reg;
	wire err = launch_try && (seq_err || clk_err || !d_legal);
	// Loading the buffer while it is full breaks the sequence
	wire load_err = wr_load && !cmd_buffer_empty_flag_reg;

	// Protected region sits at and above the base address
	always @* begin
		target = addr_reg;
		if (d_page) begin
			target = addr_reg | {{(AW-`FCSU_PAGE_BITS){1'b0}}, {`FCSU_PAGE_BITS{1'b1}}};
		end
	end
	wire prot_hit = d_prog && prot_en_reg && (d_mass || (target >= prot_base_reg));
	wire viol = launch_try && !err && prot_hit;
	wire go = launch_try && !err && !prot_hit;

	// Stop while anything runs or waits aborts it
	wire stop_abort = stop_req && busy;
	wire start = pend_reg && !arr_busy && !stop_req;

	// ======================================================
	// Array handshake
	fcsu_arr_ctl #(
		.AW(AW)
	) u_arr (
		.pclk(pclk),
		.presetn(presetn),
		.start(start),
		.op(pend_op_reg),
		.addr(pend_addr_reg),
		.wdata(pend_data_reg),
		.abort(stop_abort),
		.arr_done(arr_done),
		.arr_rvalid(arr_rvalid),
		.arr_rdata(arr_rdata),
		.busy(arr_busy),
		.done(arr_fin),
		.blank_ok(arr_blank_ok),
		.arr_req(arr_req),
		.arr_op(arr_op),
		.arr_addr(arr_addr),
		.arr_wdata(arr_wdata),
		.arr_abort(arr_abort)
	);

	// Blank result is taken when the operation ends
	wire blank_pass = arr_fin && cur_blank_reg && arr_blank_ok;

	// ======================================================
	// Buffer-empty flag: cleared by launch, set on stop, when a burst leaves the slot, or when an operation ends with the slot empty
	reg cbef_next;
	always @* begin
		cbef_next = cmd_buffer_empty_flag_reg;
		if (go) begin
			cbef_next = 1'b0;
		end else if (stop_abort) begin
			cbef_next = 1'b1;
		end else if (start && pend_burst_reg) begin
			cbef_next = 1'b1;
		end else if (arr_fin && !pend_reg) begin
			cbef_next = 1'b1;
		end
	end

	// Complete is derived from activity only; bus writes never reach it
	wire ccf_next = !go && cmd_buffer_empty_flag_reg && !pend_reg && !arr_busy && !start;

	// ======================================================
	// Interrupt events: complete rise, violation, error, blank pass
	wire acc_set = err || load_err || stop_abort;
	wire [`FCSU_IRQ_W-1:0] ev = {blank_pass, acc_set, viol,
		ccf_next && !cmd_complete_flag_reg};
	wire [`FCSU_IRQ_W-1:0] iclr = (wr && paddr == `FCSU_OFF_ISTAT) ?
		pwdata[`FCSU_IRQ_W-1:0] : {`FCSU_IRQ_W{1'b0}};

	// ======================================================
	// Status and command flags; violation and error sets beat a same-cycle clear, a launch beats a blank pass
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_buffer_empty_flag_reg <= 1'b1;
			cmd_complete_flag_reg <= 1'b1;
			protect_violation_flag_reg <= 1'b0;
			access_error_flag_reg <= 1'b0;
			array_blank_flag_reg <= 1'b0;
		end else begin
			cmd_buffer_empty_flag_reg <= cbef_next;
			cmd_complete_flag_reg <= ccf_next;
			if (viol) begin
				protect_violation_flag_reg <= 1'b1;
			end else if (wr_stat && pwdata[`FCSU_BIT_PVIOL]) begin
				protect_violation_flag_reg <= 1'b0;
			end
			if (acc_set) begin
				access_error_flag_reg <= 1'b1;
			end else if (wr_stat && pwdata[`FCSU_BIT_ACCERR]) begin
				access_error_flag_reg <= 1'b0;
			end
			if (go) begin
				array_blank_flag_reg <= 1'b0;
			end else if (blank_pass) begin
				array_blank_flag_reg <= 1'b1;
			end
		end
	end

	// ======================================================
	// Loadable registers and the one-deep launch slot
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flash_command_code_reg <= 8'h00;
			loaded_reg <= 1'b0;
			addr_reg <= {AW{1'b0}};
			data_reg <= 8'h00;
			div_ready_reg <= 1'b0;
			prot_en_reg <= 1'b0;
			prot_base_reg <= {AW{1'b0}};
			pend_reg <= 1'b0;
			pend_op_reg <= `FCSU_OP_NONE;
			pend_burst_reg <= 1'b0;
			pend_addr_reg <= {AW{1'b0}};
			pend_data_reg <= 8'h00;
			cur_blank_reg <= 1'b0;
			cur_burst_reg <= 1'b0;
			imask_reg <= {`FCSU_IRQ_W{1'b0}};
		end else begin
			if (wr_load && !load_err && paddr == `FCSU_OFF_CMD) begin
				flash_command_code_reg <= pwdata[7:0];
				loaded_reg <= 1'b1;
			end else if (launch_try) begin
				loaded_reg <= 1'b0; // Each launch needs a fresh load
			end
			if (wr_load && !load_err && paddr == `FCSU_OFF_ADDR) begin
				addr_reg <= pwdata[AW-1:0];
			end
			if (wr_load && !load_err && paddr == `FCSU_OFF_DATA) begin
				data_reg <= pwdata[7:0];
			end
			if (wr && paddr == `FCSU_OFF_CTRL) begin
				div_ready_reg <= pwdata[`FCSU_BIT_DIV_READY];
				prot_en_reg <= pwdata[`FCSU_BIT_PROT_EN];
				prot_base_reg <= pwdata[`FCSU_PROT_BASE_LSB +: AW];
			end
			if (wr && paddr == `FCSU_OFF_IMASK) begin
				imask_reg <= pwdata[`FCSU_IRQ_W-1:0];
			end
			if (go) begin
				pend_reg <= 1'b1;
				pend_op_reg <= d_op;
				pend_burst_reg <= d_burst;
				pend_addr_reg <= addr_reg;
				pend_data_reg <= data_reg;
			end else if (start || stop_abort) begin
				pend_reg <= 1'b0;
			end
			if (start) begin
				cur_blank_reg <= (pend_op_reg == `FCSU_OP_BLANK);
				cur_burst_reg <= pend_burst_reg;
			end
		end
	end

	// ======================================================
	// Security state: strap caught after reset release
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			security_state_code <= `FCSU_SEC_RESET;
			sec_loaded_reg <= 1'b0;
		end else begin
			sec_loaded_reg <= 1'b1;
			if (blank_pass || key_ok) begin
				security_state_code <= `FCSU_SEC_UNSECURED;
			end else if (!sec_loaded_reg) begin
				security_state_code <= sec_strap;
			end
		end
	end

	// ======================================================
	// Interrupt status, W1C; an event in the clear cycle survives
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			istat_reg <= {`FCSU_IRQ_W{1'b0}};
			irq <= 1'b0;
		end else begin
			istat_reg <= (istat_reg & ~iclr) | ev;
			irq <= |(istat_reg & imask_reg);
		end
	end

	// ======================================================
	// Read mux; reserved status bits stay zero
	always @* begin
		rdata_next = 32'h00000000;
		case (paddr)
			`FCSU_OFF_STATUS: begin
				rdata_next[`FCSU_BIT_CBEF] = cmd_buffer_empty_flag_reg;
				rdata_next[`FCSU_BIT_CCF] = cmd_complete_flag_reg;
				rdata_next[`FCSU_BIT_PVIOL] = protect_violation_flag_reg;
				rdata_next[`FCSU_BIT_ACCERR] = access_error_flag_reg;
				rdata_next[`FCSU_BIT_BLANK] = array_blank_flag_reg;
			end
			`FCSU_OFF_CMD: rdata_next[7:0] = flash_command_code_reg;
			`FCSU_OFF_ADDR: rdata_next[AW-1:0] = addr_reg;
			`FCSU_OFF_DATA: rdata_next[7:0] = data_reg;
			`FCSU_OFF_CTRL: begin
				rdata_next[`FCSU_BIT_DIV_READY] = div_ready_reg;
				rdata_next[`FCSU_BIT_PROT_EN] = prot_en_reg;
				rdata_next[`FCSU_PROT_BASE_LSB +: AW] = prot_base_reg;
			end
			`FCSU_OFF_SEC: rdata_next[1:0] = security_state_code;
			`FCSU_OFF_ISTAT: rdata_next[`FCSU_IRQ_W-1:0] = istat_reg;
			`FCSU_OFF_IMASK: rdata_next[`FCSU_IRQ_W-1:0] = imask_reg;
			default: rdata_next = 32'h00000000;
		endcase
	end

	// ======================================================
	// APB answer: one wait state, so every access takes three edges
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			if (psel && penable && !pready) begin
				pready <= 1'b1;
				pslverr <= !known_addr(paddr);
				prdata <= pwrite ? 32'h00000000 : rdata_next;
			end else begin
				pready <= 1'b0;
				pslverr <= 1'b0;
			end
		end
	end

endmodule

// [design/fcsu_consts.vh]
// Shared offsets, field positions, reset values and command codes
`ifndef FCSU_CONSTS_VH
`define FCSU_CONSTS_VH

// ==========================================================
// Register byte offsets on the APB port
`define FCSU_OFF_STATUS 8'h00
`define FCSU_OFF_CMD 8'h04
`define FCSU_OFF_ADDR 8'h08
`define FCSU_OFF_DATA 8'h0c
`define FCSU_OFF_CTRL 8'h10
`define FCSU_OFF_SEC 8'h14
`define FCSU_OFF_ISTAT 8'h18
`define FCSU_OFF_IMASK 8'h1c

// ==========================================================
// Status register field positions
`define FCSU_BIT_CBEF 7
`define FCSU_BIT_CCF 6
`define FCSU_BIT_PVIOL 5
`define FCSU_BIT_ACCERR 4
`define FCSU_BIT_BLANK 2

// ==========================================================
// Control register field positions
`define FCSU_BIT_DIV_READY 0
`define FCSU_BIT_PROT_EN 1
`define FCSU_PROT_BASE_LSB 16

// ==========================================================
// Interrupt status and mask bit positions
`define FCSU_IRQ_DONE 0
`define FCSU_IRQ_PVIOL 1
`define FCSU_IRQ_ACCERR 2
`define FCSU_IRQ_BLANK 3
`define FCSU_IRQ_W 4

// ==========================================================
// Command codes
`define FCSU_CMD_BLANK 8'h05
`define FCSU_CMD_BYTE 8'h20
`define FCSU_CMD_BURST 8'h25
`define FCSU_CMD_PAGE 8'h40
`define FCSU_CMD_MASS 8'h41

// ==========================================================
// Operation codes driven to the array
`define FCSU_OP_NONE 3'h0
`define FCSU_OP_BLANK 3'h1
`define FCSU_OP_BYTE 3'h2
`define FCSU_OP_BURST 3'h3
`define FCSU_OP_PAGE 3'h4
`define FCSU_OP_MASS 3'h5

// ==========================================================
// Misc values
`define FCSU_ERASED_BYTE 8'hff
`define FCSU_PAGE_BITS 9
`define FCSU_SEC_UNSECURED 2'h2
`define FCSU_SEC_RESET 2'h0

`endif

// [design/fcsu_cmd_decode.v]
// Command code decoder: legality and operation class
`timescale 1ns/1ps
`include "fcsu_consts.vh"

module fcsu_cmd_decode (
	input wire [7:0] code,
	output reg legal,
	output reg is_prog,
	output reg is_burst,
	output reg is_blank,
	output reg is_mass,
	output reg is_page,
	output reg [2:0] op
);

	// ======================================================
	// Decode table; anything else is illegal
	always @* begin
		legal = 1'b1;
		is_prog = 1'b0;
		is_burst = 1'b0;
		is_blank = 1'b0;
		is_mass = 1'b0;
		is_page = 1'b0;
		op = `FCSU_OP_NONE;
		case (code)
			`FCSU_CMD_BLANK: begin
				is_blank = 1'b1;
				op = `FCSU_OP_BLANK;
			end
			`FCSU_CMD_BYTE: begin
				is_prog = 1'b1;
				op = `FCSU_OP_BYTE;
			end
			`FCSU_CMD_BURST: begin
				is_prog = 1'b1;
				is_burst = 1'b1;
				op = `FCSU_OP_BURST;
			end
			`FCSU_CMD_PAGE: begin
				is_prog = 1'b1;
				is_page = 1'b1;
				op = `FCSU_OP_PAGE;
			end
			`FCSU_CMD_MASS: begin
				is_prog = 1'b1;
				is_mass = 1'b1;
				op = `FCSU_OP_MASS;
			end
			default: begin
				legal = 1'b0;
			end
		endcase
	end

endmodule

// [design/fcsu_arr_ctl.v]
// Array handshake: holds a request until the array reports done or an abort drops it
`timescale 1ns/1ps
`include "fcsu_consts.vh"

module fcsu_arr_ctl #(
	parameter AW = 16
) (
	input wire pclk,
	input wire presetn,
	input wire start,
	input wire [2:0] op,
	input wire [AW-1:0] addr,
	input wire [7:0] wdata,
	input wire abort,
	input wire arr_done,
	input wire arr_rvalid,
	input wire [7:0] arr_rdata,
	output reg busy,
	output reg done,
	output reg blank_ok,
	output reg arr_req,
	output reg [2:0] arr_op,
	output reg [AW-1:0] arr_addr,
	output reg [7:0] arr_wdata,
	output reg arr_abort
);

	localparam ST_IDLE = 1'b0;
	localparam ST_RUN = 1'b1;

	reg state_reg;
	reg all_ff_reg;
	wire bad_byte;

	// A non-erased byte seen during a blank check spoils the result
	assign bad_byte = arr_rvalid && (arr_rdata != `FCSU_ERASED_BYTE);

	// ======================================================
	// Request sequencer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			busy <= 1'b0;
			done <= 1'b0;
			blank_ok <= 1'b0;
			arr_req <= 1'b0;
			arr_op <= `FCSU_OP_NONE;
			arr_addr <= {AW{1'b0}};
			arr_wdata <= 8'h00;
			arr_abort <= 1'b0;
			all_ff_reg <= 1'b1;
		end else begin
			done <= 1'b0;
			arr_abort <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (start) begin
						state_reg <= ST_RUN;
						busy <= 1'b1;
						arr_req <= 1'b1;
						arr_op <= op;
						arr_addr <= addr;
						arr_wdata <= wdata;
						all_ff_reg <= 1'b1;
					end
				end
				ST_RUN: begin
					if (abort) begin
						// Stop mode kills the operation outright
						state_reg <= ST_IDLE;
						busy <= 1'b0;
						arr_req <= 1'b0;
						arr_abort <= 1'b1;
					end else if (arr_done) begin
						state_reg <= ST_IDLE;
						busy <= 1'b0;
						arr_req <= 1'b0;
						done <= 1'b1;
						blank_ok <= all_ff_reg && !bad_byte;
					end else if (bad_byte) begin
						all_ff_reg <= 1'b0;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
					busy <= 1'b0;
					arr_req <= 1'b0;
				end
			endcase
		end
	end

endmodule

// [bench/fcsu_assertions.sv]
// Port checker for the flash command launch and status unit
`timescale 1ns/1ps
// ==========
// Checker
module fcsu_chk #(
	parameter AW = 16
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pready,
	input wire pslverr,
	input wire stop_req,
	input wire key_ok,
	input wire [1:0] security_state_code,
	input wire arr_done,
	input wire arr_req,
	input wire [2:0] arr_op,
	input wire [AW-1:0] arr_addr,
	input wire [7:0] arr_wdata,
	input wire arr_abort
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// First access cycle of an APB transfer
	sequence apb_wait;
		psel && penable && !pready;
	endsequence
	// Array request that nothing ends this cycle
	sequence req_open;
		arr_req && !arr_done && !arr_abort && !stop_req;
	endsequence
	wait_state_a: assert property (apb_wait |=> pready)
		else $error("pready late");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held");
	slverr_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr alone");
	req_hold_a: assert property (
		req_open |=> arr_req && $stable(arr_op) && $stable(arr_addr) && $stable(arr_wdata))
		else $error("request moved");
	done_drop_a: assert property (arr_req && arr_done |=> !arr_req)
		else $error("request after done");
	abort_pulse_a: assert property (arr_abort |=> !arr_abort)
		else $error("abort held");
	stop_drop_a: assert property (arr_req && stop_req |-> ##[1:2] !arr_req)
		else $error("stop ignored");
	op_legal_a: assert property (arr_req |-> arr_op != 3'h0 && arr_op <= 3'h5)
		else $error("bad op");
	key_unsec_a: assert property (key_ok |-> ##[1:2] security_state_code == 2'h2)
		else $error("key ignored");
endmodule
bind fcsu_top fcsu_chk #(.AW(AW)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .stop_req(stop_req),
	.key_ok(key_ok), .security_state_code(security_state_code), .arr_done(arr_done),
	.arr_req(arr_req), .arr_op(arr_op), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
	.arr_abort(arr_abort));

// [bench/fcsu_flash_model.sv]
// Behavioural flash array answering the unit's array handshake
`timescale 1ns/1ps
`include "fcsu_consts.vh"
// ==========
// Array model
module fcsu_flash_model (
	input wire pclk,
	input wire presetn,
	input wire [7:0] lat,
	input wire arr_req,
	input wire [2:0] arr_op,
	input wire [7:0] arr_wdata,
	input wire arr_abort,
	output reg arr_done,
	output reg arr_rvalid,
	output reg [7:0] arr_rdata
);
	reg [7:0] cnt;
	reg dirty;
	// One op at a time; read bus toggles when idle so stale data never looks valid
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 8'h00;
			dirty <= 1'b0;
			arr_done <= 1'b0;
			arr_rvalid <= 1'b0;
			arr_rdata <= 8'h5a;
		end else begin
			arr_done <= 1'b0;
			arr_rvalid <= 1'b0;
			arr_rdata <= ~arr_rdata;
			cnt <= cnt + 8'h01;
			if (!arr_req || arr_abort || arr_done)
				cnt <= 8'h00;
			if (arr_req && cnt == lat - 8'h01 && arr_op == `FCSU_OP_BLANK) begin
				arr_rvalid <= 1'b1;
				arr_rdata <= dirty ? 8'h00 : `FCSU_ERASED_BYTE;
			end
			if (arr_req && !arr_done && cnt == lat) begin
				arr_done <= 1'b1;
				if (arr_op == `FCSU_OP_BYTE || arr_op == `FCSU_OP_BURST)
					dirty <= dirty | (arr_wdata != `FCSU_ERASED_BYTE);
				if (arr_op == `FCSU_OP_PAGE || arr_op == `FCSU_OP_MASS)
					dirty <= 1'b0;
			end
		end
	end
endmodule

// [bench/tb_flash_command_status_unit.sv]
// Self-checking bench for the flash command launch and status unit
`timescale 1ns/1ps
`include "fcsu_consts.vh"
// ==========
// Bench top
module tb_flash_command_status_unit;
	reg pclk = 1'b0;
	reg presetn = 1'b0;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0;
	reg stop_req = 1'b0;
	reg key_ok = 1'b0;
	reg [1:0] sec_strap = 2'h0;
	reg [7:0] lat = 8'h03; // Array latency in edges, raised later for the slot test
	wire [31:0] prdata;
	wire pready, pslverr, irq, arr_done, arr_rvalid, arr_req, arr_abort;
	wire [1:0] sec;
	wire [2:0] arr_op;
	wire [7:0] arr_rdata, arr_wdata;
	wire [15:0] arr_addr;
	reg [31:0] q;
	reg err;
	integer failures = 0;
	integer n_tests = 0;
	integer i;
	// Command sequence, expected op nibble and status byte after each
	reg [47:0] cmds = 48'h20_05_41_05_40_25;
	reg [23:0] ops = 24'h215143;
	reg [47:0] stats = 48'hc0_c0_c0_c4_c0_c0;
	fcsu_top #(.AW(16)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .stop_req(stop_req), .key_ok(key_ok), .sec_strap(sec_strap),
		.security_state_code(sec), .irq(irq), .arr_done(arr_done), .arr_rvalid(arr_rvalid),
		.arr_rdata(arr_rdata), .arr_req(arr_req), .arr_op(arr_op), .arr_addr(arr_addr),
		.arr_wdata(arr_wdata), .arr_abort(arr_abort));
	fcsu_flash_model u_flash (.pclk(pclk), .presetn(presetn), .lat(lat), .arr_req(arr_req),
		.arr_op(arr_op), .arr_wdata(arr_wdata), .arr_abort(arr_abort), .arr_done(arr_done),
		.arr_rvalid(arr_rvalid), .arr_rdata(arr_rdata));
	initial begin
		forever #2 pclk = ~pclk;
	end
	// ==========
	// Tasks
	task summarize;
		begin
			$display("comparisons %0d mismatches %0d", n_tests, failures);
			if (failures == 0 && n_tests > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_tests = n_tests + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	// A used-up wait is a mismatch and ends the run
	task bound(input integer k, input integer n);
		begin
			if (k >= n) begin
				failures = failures + 1;
				$display("mismatch at %0t: wait limit reached", $time);
				summarize;
			end
		end
	endtask
	// APB transfer; one idle cycle after it so no signal is set twice in a step
	task xfer(input w, input [7:0] a, input [31:0] d);
		integer k;
		begin
			k = 0;
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			do begin
				@(posedge pclk);
				k = k + 1;
			end while (pready !== 1'b1 && k < 20);
			bound(k, 20);
			q = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask
	task st(input [7:0] e);
		begin
			xfer(1'b0, `FCSU_OFF_STATUS, 32'h0);
			chk(q, {24'h0, e});
		end
	endtask
	task run(input [7:0] c, input [31:0] a);
		begin
			xfer(1'b1, `FCSU_OFF_CMD, {24'h0, c});
			xfer(1'b1, `FCSU_OFF_ADDR, a);
			xfer(1'b1, `FCSU_OFF_DATA, 32'h0);
			xfer(1'b1, `FCSU_OFF_STATUS, 32'h80);
		end
	endtask
	task wait_req;
		integer k;
		begin
			k = 0;
			while (arr_req !== 1'b1 && k < 10) begin
				@(posedge pclk);
				k = k + 1;
			end
			bound(k, 10);
		end
	endtask
	// Polls status until the complete flag shows
	task wait_idle;
		integer k;
		begin
			k = 0;
			do begin
				xfer(1'b0, `FCSU_OFF_STATUS, 32'h0);
				k = k + 1;
			end while (q[6] !== 1'b1 && k < 100);
			bound(k, 100);
		end
	endtask
	// ==========
	// Main sequence
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		st(8'hc0);
		xfer(1'b0, 8'h40, 32'h0);
		chk(q | {err, 31'h0}, 32'h8000_0000);
		xfer(1'b1, `FCSU_OFF_CTRL, 32'h1);
		xfer(1'b1, `FCSU_OFF_IMASK, 32'hf);
		// Every command code, program then blank check before and after erase
		for (i = 0; i < 6; i = i + 1) begin
			run(cmds[47-8*i -: 8], 32'h0);
			wait_req;
			chk({29'h0, arr_op}, {28'h0, ops[23-4*i -: 4]});
			wait_idle;
			chk(q, {24'h0, stats[47-8*i -: 8]});
		end
		chk({30'h0, sec}, 32'h2);
		xfer(1'b1, `FCSU_OFF_STATUS, 32'h0f);
		st(8'hc0);
		chk({31'h0, irq}, 32'h1);
		xfer(1'b1, `FCSU_OFF_ISTAT, 32'hf);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		xfer(1'b1, `FCSU_OFF_IMASK, 32'h0);
		// Illegal code, then W1C with zero and with one
		run(8'h33, 32'h0);
		st(8'hd0);
		chk({31'h0, arr_req}, 32'h0);
		xfer(1'b1, `FCSU_OFF_STATUS, 32'h0);
		st(8'hd0);
		xfer(1'b0, `FCSU_OFF_ISTAT, 32'h0);
		chk({30'h0, q[2], irq}, 32'h2);
		xfer(1'b1, `FCSU_OFF_STATUS, 32'h10);
		st(8'hc0);
		// Protected target, then divider not ready
		xfer(1'b1, `FCSU_OFF_CTRL, 32'h0100_0003);
		run(8'h20, 32'h0200);
		st(8'he0);
		// Writing zero must not clear the violation
		xfer(1'b1, `FCSU_OFF_STATUS, 32'h0);
		st(8'he0);
		xfer(1'b1, `FCSU_OFF_STATUS, 32'h20);
		st(8'hc0);
		xfer(1'b1, `FCSU_OFF_CTRL, 32'h0);
		run(8'h40, 32'h0);
		st(8'hd0);
		xfer(1'b1, `FCSU_OFF_STATUS, 32'h10);
		xfer(1'b1, `FCSU_OFF_CTRL, 32'h1);
		// Slow array: second burst waits in the slot; latency leaves a wide margin
		lat <= 8'h30;
		run(8'h25, 32'h0);
		wait_req;
		st(8'h80);
		run(8'h25, 32'h1);
		st(8'h00);
		wait_idle;
		chk(q, 32'hc0);
		// Stop mode during a running erase
		run(8'h41, 32'h0123);
		wait_req;
		chk({16'h0, arr_addr}, 32'h0123);
		stop_req <= 1'b1;
		@(posedge pclk);
		stop_req <= 1'b0;
		wait_idle;
		chk(q, 32'hd0);
		// Reset while idle, then key entry
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		st(8'hc0);
		chk({30'h0, sec}, 32'h0);
		key_ok <= 1'b1;
		@(posedge pclk);
		key_ok <= 1'b0;
		repeat (2) @(posedge pclk);
		chk({30'h0, sec}, 32'h2);
		summarize;
	end
endmodule
